// [core/lpiv_ctrl.sv]
// Low-power mode decode, clock gating, vector arbitration and enable register.
`timescale 1ns/1ps

module lpiv_ctrl
    import lpiv_pkg::*;
#(
    parameter int UNUSED_LO = 16'h0400  // Start of an unmapped gap in fetch space.
) (
    // Clock and resets.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        por_i,
    // Wishbone slave.
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // CPU core side.
    input  wire logic        fetch_i,
    input  wire logic [15:0] fetch_addr_i,
    input  wire logic        reti_i,
    input  wire logic        irq_ack_i,
    input  wire logic [15:0] reset_word_i,
    input  wire logic [15:0] key_word_i,
    input  wire logic        dco_used_active_i,
    input  wire logic        i2c_mode_i,
    input  wire logic        wdt_interval_mode_i,
    // Event sources.
    input  wire logic        pin_reset_i,
    input  wire logic        pin_nmi_i,
    input  wire logic        osc_fault_i,
    input  wire logic        flash_accv_i,
    input  wire logic        reset_src_i,
    input  wire lpiv_irq_t   irq_i,
    // Outputs to core and clock system.
    output logic             irq_req_o,
    output logic [15:0]      vec_addr_o,
    output logic [4:0]       vec_prio_o,
    output logic             cpu_halt_o,
    output lpiv_clk_t        clk_gate_o,
    output logic             fetch_reset_o,
    output logic             loader_off_o,
    output logic             no_erase_o
);

    // Vector words sit two bytes apart from the bottom of the vector area.
    // Slot p therefore lives at the base plus twice p.
    // The top slot is the reset word, slot 30 the shared non-maskable word.
    // Keeping this in one function stops the request path and the status
    // view from drifting apart if the base ever moves.

    // Priority-to-address function shared by arbitration and status.
    function automatic logic [15:0] prio_addr(input logic [4:0] p);
        prio_addr = VEC_BASE + {10'h000, p, 1'b0};
    endfunction

    logic [7:0]  ie_one_q;
    logic [7:0]  mode_ctl_q;
    logic [7:0]  mode_save_q;
    logic        in_isr_q;
    logic        por_flag_q;
    logic        ext_flag_q;
    logic        boot_chk_q;
    logic [2:0]  pin_sync_q;
    logic        pin_lvl_q;
    logic        pin_evt;
    logic        pin_flag_q;
    lpiv_mode_t  mode_d;
    logic        pend;
    logic [4:0]  win_prio;
    logic        sleeping;
    logic        bus_hit;

    // Pin NMI crosses in via three flops; an edge counts when stages 2 and 3 agree.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_sync_q <= 3'h0;
            pin_lvl_q  <= 1'b0;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], pin_nmi_i};
            if (pin_sync_q[2] == pin_sync_q[1]) begin
                pin_lvl_q <= pin_sync_q[2];
            end
        end
    end
    assign pin_evt = (pin_sync_q[2] == pin_sync_q[1]) && pin_sync_q[2] && !pin_lvl_q;

    // The level register starts low, the idle level of the pin.
    // A pin that idles high would show one false edge after reset.
    // Users who tie the pin high must mask the event until it settles.

    // The edge is a one-cycle pulse, but a core may take several cycles to
    // answer, so the event is latched here until the core takes the vector.
    // A new edge in the cycle of the acknowledge wins over the clear.
    // Limitation: an acknowledge of slot 30 clears the latch even when the
    // oscillator or flash source was the cause; software polls all three.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_flag_q <= 1'b0;
        end else if (pin_evt) begin
            pin_flag_q <= 1'b1;
        end else if (irq_ack_i && vec_prio_o == PRIO_NMI) begin
            pin_flag_q <= 1'b0;
        end
    end

    // The power-on input is a level from the supply monitor.
    // It is sampled on the system clock, so it must stand for at least
    // one edge; a shorter glitch may be missed entirely.

    // Power-on flags survive power-up clear; only the power-on reset forces them.
    always_ff @(posedge clk_i) begin
        if (por_i) begin
            por_flag_q <= 1'b1;
            ext_flag_q <= 1'b0;
        end else if (pin_reset_i) begin
            ext_flag_q <= 1'b1;
        end
    end

    // One process owns the mode bits, so the boot check, the interrupt
    // entry, the handler return and a bus write are put in strict order.
    // A bus write that meets one of the others in the same cycle is lost.
    // Software must not rewrite the mode bits while an interrupt is due.
    // The write still gets its acknowledge; only the data is dropped.

    // Register interface: enable and mode control, cleared by power-up clear.
    assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ie_one_q    <= IE_ONE_RST;
            mode_ctl_q  <= MODE_CTL_RST;
            mode_save_q <= MODE_CTL_RST;
            in_isr_q    <= 1'b0;
            boot_chk_q  <= 1'b1;
        end else begin
            boot_chk_q <= 1'b0;
            // Erased reset vector means no program: park in the deepest mode.
            if (boot_chk_q && reset_word_i == ERASED_WORD) begin
                mode_ctl_q <= MODE_CTL_RST | 8'h0f;
            end else if (irq_ack_i && !in_isr_q) begin
                // Handler runs awake; the sleep bits are saved for return.
                mode_save_q <= mode_ctl_q;
                mode_ctl_q  <= mode_ctl_q & ~8'h0f;
                in_isr_q    <= 1'b1;
            end else if (reti_i && in_isr_q) begin
                mode_ctl_q <= mode_save_q;
                in_isr_q   <= 1'b0;
            end else if (bus_hit && wb_we_i && wb_sel_i[0]) begin
                if (wb_adr_i == IE_ONE_OFF) begin
                    ie_one_q <= wb_dat_i[7:0] & IE_ONE_MASK;
                end
                if (wb_adr_i == MODE_CTL_OFF) begin
                    mode_ctl_q <= wb_dat_i[7:0] & MODE_CTL_MASK;
                end
            end
        end
    end

    // Combinations outside the five documented ones fold to the nearest
    // safe mode: with the oscillator off the deepest mode, else mode zero.
    // This keeps an odd software value from leaving a clock half gated.

    // Decode the status bits into an operating mode.
    always_comb begin
        mode_d = MODE_ACTIVE;
        if (mode_ctl_q[CPU_OFF_BIT]) begin
            case ({mode_ctl_q[SCG1_BIT], mode_ctl_q[SCG0_BIT], mode_ctl_q[OSC_OFF_BIT]})
                3'b000:  mode_d = MODE_SLEEP0;
                3'b010:  mode_d = MODE_SLEEP1;
                3'b100:  mode_d = MODE_SLEEP2;
                3'b110:  mode_d = MODE_SLEEP3;
                3'b111:  mode_d = MODE_SLEEP4;
                default: mode_d = mode_ctl_q[OSC_OFF_BIT] ? MODE_SLEEP4 : MODE_SLEEP0;
            endcase
        end
    end
    assign sleeping = (mode_d != MODE_ACTIVE);

    // Each enable is high while its clock or generator runs.
    // The gates lag the mode bits by one edge; the clock system downstream
    // must tolerate that extra cycle on entry and on wake.
    // Sleep one keeps the generator on only if the core needs it awake.

    // Clock gating per mode; everything registered on the way out.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_gate_o <= '1;
            cpu_halt_o <= 1'b0;
        end else begin
            cpu_halt_o <= sleeping;
            case (mode_d)
                MODE_ACTIVE: clk_gate_o <= '1;
                MODE_SLEEP0: clk_gate_o <= 5'b11011;
                MODE_SLEEP1: clk_gate_o <= {3'b110, dco_used_active_i, 1'b1};
                MODE_SLEEP2: clk_gate_o <= 5'b10011;
                MODE_SLEEP3: clk_gate_o <= 5'b10001;
                MODE_SLEEP4: clk_gate_o <= 5'b00000;
                default:     clk_gate_o <= '1;
            endcase
        end
    end

    // The reset source outranks all; the three non-maskable sources follow
    // and ignore the global enable, but each obeys its own enable bit.
    // Maskable sources are levels held by their peripherals until the
    // handler clears them, so nothing needs to be latched for them here.
    // The watchdog slot only exists while the watchdog is an interval timer.
    // In the two-wire mode the second serial unit routes its status flags
    // to the receive slot and both data flags to the transmit slot.

    // Fixed-priority arbitration; higher slots are checked first.
    always_comb begin
        pend     = 1'b1;
        win_prio = 5'd0;
        if (reset_src_i) begin
            win_prio = PRIO_RESET;
        end else if ((pin_flag_q && ie_one_q[IE_NMI_BIT])
                     || (osc_fault_i && ie_one_q[IE_OSC_BIT])
                     || (flash_accv_i && ie_one_q[IE_ACCV_BIT])) begin
            win_prio = PRIO_NMI;
        end else if (!mode_ctl_q[GIE_BIT]) begin
            pend = 1'b0;
        end else if (irq_i.t1_cc0) begin
            win_prio = 5'd29;
        end else if (irq_i.t1_other) begin
            win_prio = 5'd28;
        end else if (irq_i.comparator) begin
            win_prio = 5'd27;
        end else if (irq_i.wdt_interval && (!wdt_interval_mode_i || ie_one_q[IE_WDT_BIT])
                     && wdt_interval_mode_i) begin
            win_prio = 5'd26;
        end else if (irq_i.t0_cc0) begin
            win_prio = 5'd25;
        end else if (irq_i.t0_other) begin
            win_prio = 5'd24;
        end else if (irq_i.ser_a_rx || (i2c_mode_i ? irq_i.i2c_status : irq_i.ser_b_rx)) begin
            win_prio = 5'd23;
        end else if (irq_i.ser_a_tx || irq_i.ser_b_tx || (i2c_mode_i && irq_i.ser_b_rx)) begin
            win_prio = 5'd22;
        end else if (irq_i.converter) begin
            win_prio = 5'd21;
        end else if (|irq_i.port_two) begin
            win_prio = 5'd19;
        end else if (|irq_i.port_one) begin
            win_prio = 5'd18;
        end else begin
            pend = 1'b0;  // Slots 16, 17, 20 and 15 down are never requested
        end
    end

    // No nesting: the request is held low while a handler runs.
    // A source that rises during a handler is seen after the return.
    // The vector and its priority move with the request, so the core may
    // latch them in the same cycle as it sees the request.

    // Registered request and vector towards the core.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_req_o  <= 1'b0;
            vec_prio_o <= PRIO_RESET;
            vec_addr_o <= VEC_RESET;
        end else begin
            irq_req_o  <= pend && !in_isr_q;
            vec_prio_o <= win_prio;
            vec_addr_o <= prio_addr(win_prio);
        end
    end

    // The fetch guard covers the module registers and one unmapped gap.
    // Its pulse comes one cycle after the fetch; the reset logic outside
    // must act on it before the fetched word reaches the core.
    // The key words are plain compares, registered to keep outputs clean.

    // Fetch guard and loader key decode.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fetch_reset_o <= 1'b0;
            loader_off_o  <= 1'b0;
            no_erase_o    <= 1'b0;
        end else begin
            fetch_reset_o <= fetch_i && ((fetch_addr_i <= MODREG_LAST)
                             || (fetch_addr_i >= UNUSED_LO[15:0] && fetch_addr_i < 16'h1000));
            loader_off_o  <= (key_word_i == KEY_DISABLE);
            no_erase_o    <= (key_word_i == KEY_NO_ERASE);
        end
    end

    // The acknowledge is blocked for one cycle after it is given, so a
    // master that holds its strobe is never answered twice for one request.
    // Read data stands only in the acknowledge cycle and is zero otherwise.

    // Wishbone answer one cycle after the request; unmapped reads return zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= bus_hit;
            wb_dat_o <= 32'h0000_0000;
            if (bus_hit && !wb_we_i) begin
                case (wb_adr_i)
                    IE_ONE_OFF:   wb_dat_o <= {24'h000000, ie_one_q};
                    MODE_CTL_OFF: wb_dat_o <= {24'h000000, mode_ctl_q};
                    STATUS_OFF:   wb_dat_o <= {8'h00, vec_addr_o, in_isr_q, pin_lvl_q,
                                               ext_flag_q, por_flag_q, 1'b0, 3'(mode_d)};
                    KEY_OFF:      wb_dat_o <= {16'h0000, key_word_i};
                    default:      wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // lpiv_ctrl

// [core/lpiv_pkg.sv]
// Package with register map, vector map, mode encodings and carrier types.
package lpiv_pkg;

    // Register map (byte addresses on the Wishbone slave).
    localparam logic [7:0] IE_ONE_OFF   = 8'h00;  // interrupt_enable_one
    localparam logic [7:0] MODE_CTL_OFF = 8'h04;  // Status-register low-power bits.
    localparam logic [7:0] STATUS_OFF   = 8'h08;  // Mode, reset flags, pending vector.
    localparam logic [7:0] KEY_OFF      = 8'h0c;  // Loader security word view.

    // interrupt_enable_one field positions and reset value.
    localparam int         IE_WDT_BIT   = 0;
    localparam int         IE_OSC_BIT   = 1;
    localparam int         IE_NMI_BIT   = 4;
    localparam int         IE_ACCV_BIT  = 5;
    localparam logic [7:0] IE_ONE_MASK  = 8'h33;
    localparam logic [7:0] IE_ONE_RST   = 8'h00;

    // Mode control field positions (status register layout of the core).
    localparam int         CPU_OFF_BIT  = 0;
    localparam int         OSC_OFF_BIT  = 1;
    localparam int         SCG0_BIT     = 2;
    localparam int         SCG1_BIT     = 3;
    localparam int         GIE_BIT      = 4;
    localparam logic [7:0] MODE_CTL_MASK = 8'h1f;
    localparam logic [7:0] MODE_CTL_RST = 8'h00;

    // Vector area and special words.
    localparam logic [15:0] VEC_BASE      = 16'hffc0;
    localparam logic [15:0] VEC_RESET     = 16'hfffe;
    localparam logic [15:0] VEC_NMI       = 16'hfffc;
    localparam logic [15:0] VEC_LOADER_KEY = 16'hffde;
    localparam logic [15:0] VEC_UNUSED_TOP = 16'hffdc;
    localparam logic [15:0] ERASED_WORD   = 16'hffff;
    localparam logic [15:0] KEY_DISABLE   = 16'haa55;
    localparam logic [15:0] KEY_NO_ERASE  = 16'h0000;
    localparam logic [15:0] MODREG_LAST   = 16'h01ff;
    localparam logic [4:0]  PRIO_RESET    = 5'd31;
    localparam logic [4:0]  PRIO_NMI      = 5'd30;

    // Operating modes.
    typedef enum logic [2:0] {
        MODE_ACTIVE, MODE_SLEEP0, MODE_SLEEP1, MODE_SLEEP2, MODE_SLEEP3, MODE_SLEEP4
    } lpiv_mode_t;

    // Maskable peripheral request flags, grouped as they arrive.
    typedef struct packed {
        logic       t1_cc0;
        logic       t1_other;
        logic       comparator;
        logic       wdt_interval;
        logic       t0_cc0;
        logic       t0_other;
        logic       ser_a_rx;
        logic       ser_b_rx;
        logic       ser_a_tx;
        logic       ser_b_tx;
        logic       i2c_status;
        logic       converter;
        logic [7:0] port_two;
        logic [7:0] port_one;
    } lpiv_irq_t;

    // Clock gate controls.
    typedef struct packed {
        logic aux_clk_en;
        logic sub_main_clk_en;
        logic main_clk_en;
        logic dco_gen_en;
        logic xtal_en;
    } lpiv_clk_t;

endpackage : lpiv_pkg

// [sim/lpiv_core_model.sv]
// Behavioural CPU core that takes vectors and returns from handlers.
`timescale 1ns/1ps
module lpiv_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic [3:0]  wait_i,
    input  wire logic        irq_req_i,
    input  wire logic [15:0] vec_addr_i,
    output logic             irq_ack_o,
    output logic             reti_o,
    output logic [15:0]      taken_vec_o
);
    // A slow core answers after wait_i cycles; the request is checked again then.
    initial begin
        irq_ack_o = 1'b0;
        reti_o = 1'b0;
        taken_vec_o = 16'h0000;
        forever begin
            @(posedge clk_i);
            if (!rst_i && irq_req_i) begin
                repeat (wait_i) @(posedge clk_i);
                if (irq_req_i) begin
                    taken_vec_o <= vec_addr_i;
                    irq_ack_o <= 1'b1;
                    @(posedge clk_i);
                    irq_ack_o <= 1'b0;
                    repeat (4) @(posedge clk_i);
                    reti_o <= 1'b1;
                    @(posedge clk_i);
                    reti_o <= 1'b0;
                end
            end
        end
    end
endmodule // lpiv_core_model

// [sim/lpiv_ctrl_properties.sv]
// Concurrent checks on the ports of the low-power vectoring block.
`timescale 1ns/1ps
module lpiv_ctrl_properties
    import lpiv_pkg::*;
(
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        fetch_i,
    input wire logic [15:0] fetch_addr_i,
    input wire logic [15:0] reset_word_i,
    input wire logic [15:0] key_word_i,
    input wire logic        irq_req_o,
    input wire logic [15:0] vec_addr_o,
    input wire logic [4:0]  vec_prio_o,
    input wire lpiv_clk_t   clk_gate_o,
    input wire logic        fetch_reset_o,
    input wire logic        loader_off_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // The key decode is registered, so the word must be seen on two edges.
    sequence s_key_off;
        (key_word_i == KEY_DISABLE) [*2];
    endsequence
    sequence s_bad_fetch;
        fetch_i && (fetch_addr_i <= MODREG_LAST || fetch_addr_i inside {[16'h0400:16'h0fff]});
    endsequence

    a_ack_follows_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("Bus request not acknowledged");
    a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("Bus acknowledge held too long");
    a_vec_from_prio: assert property (irq_req_o |-> vec_addr_o == VEC_BASE + {10'h000, vec_prio_o, 1'b0})
        else $error("Vector address does not match priority");
    a_prio_slot_used: assert property (irq_req_o |-> vec_prio_o >= 5'h12 && vec_prio_o != 5'h14)
        else $error("Request on an unused vector slot");
    a_sub_main_gate: assert property (!clk_gate_o.sub_main_clk_en |-> !clk_gate_o.main_clk_en)
        else $error("Main clock runs with sub-main clock gated");
    a_aux_off_all: assert property (!clk_gate_o.aux_clk_en |-> clk_gate_o == 5'h00)
        else $error("Clock left running with auxiliary clock off");
    a_xtal_with_aux: assert property (clk_gate_o.xtal_en == clk_gate_o.aux_clk_en)
        else $error("Crystal state differs from auxiliary clock");
    a_bad_fetch_reset: assert property (s_bad_fetch |=> fetch_reset_o)
        else $error("Illegal fetch gave no reset");
    a_key_disables: assert property (s_key_off |-> loader_off_o)
        else $error("Loader not disabled by key");
    a_erased_sleep: assert property (($fell(rst_i) && reset_word_i == ERASED_WORD) |-> ##[1:3] (clk_gate_o == 5'h00))
        else $error("Erased reset word did not stop clocks");
endmodule // lpiv_ctrl_properties

bind lpiv_ctrl lpiv_ctrl_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .fetch_i(fetch_i), .fetch_addr_i(fetch_addr_i),
    .reset_word_i(reset_word_i), .key_word_i(key_word_i), .irq_req_o(irq_req_o),
    .vec_addr_o(vec_addr_o), .vec_prio_o(vec_prio_o), .clk_gate_o(clk_gate_o),
    .fetch_reset_o(fetch_reset_o), .loader_off_o(loader_off_o));

// [sim/tb_lowpower_interrupt_vectoring.sv]
// Self-checking bench for the low-power vectoring block.
`timescale 1ns/1ps
module tb_lowpower_interrupt_vectoring;
    import lpiv_pkg::*;
    logic        clk_i, rst_i, por_i, cyc, stb, we, fetch, pin_rst, nmi, osc, accv;
    logic        dco_used, i2c, wdt_int, ack, req, halt, frst, ldr_off, no_er, irq_ack, reti;
    logic [7:0]  adr;
    logic [3:0]  cpu_wait;
    logic [4:0]  prio;
    logic [15:0] faddr, rword, kword, vec, taken;
    logic [31:0] wdat, rdat, rd;
    lpiv_irq_t   irq;
    lpiv_clk_t   gate;
    int          n_fail, comparisons;

    // Only byte lane 0 carries data and the reset source is not exercised.
    lpiv_ctrl dut_u (.clk_i(clk_i), .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .fetch_i(fetch), .fetch_addr_i(faddr), .reti_i(reti),
        .irq_ack_i(irq_ack), .reset_word_i(rword), .key_word_i(kword),
        .dco_used_active_i(dco_used), .i2c_mode_i(i2c), .wdt_interval_mode_i(wdt_int),
        .pin_reset_i(pin_rst), .pin_nmi_i(nmi), .osc_fault_i(osc), .flash_accv_i(accv),
        .reset_src_i(1'b0), .irq_i(irq), .irq_req_o(req), .vec_addr_o(vec), .vec_prio_o(prio),
        .cpu_halt_o(halt), .clk_gate_o(gate), .fetch_reset_o(frst), .loader_off_o(ldr_off),
        .no_erase_o(no_er));
    lpiv_core_model core_u (.clk_i(clk_i), .rst_i(rst_i), .wait_i(cpu_wait), .irq_req_i(req),
        .vec_addr_i(vec), .irq_ack_o(irq_ack), .reti_o(reti), .taken_vec_o(taken));

    // Free-running 100 MHz clock.
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Bounded wait for a handshake line; a missing answer counts as a mismatch.
    task automatic wait_sig(ref logic s);
        int t;
        t = 0;
        do begin
            @(posedge clk_i);
            t++;
        end while (s !== 1'b1 && t < 60);
        check({31'h0, s}, 32'h1);
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        wait_sig(ack);
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic do_reset();
        rst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // Core takes the vector, the handler clears every source, then returns.
    task automatic take(input logic [15:0] exp);
        wait_sig(irq_ack);
        irq <= '0;
        {osc, accv, nmi} <= 3'h0;
        wait_sig(reti);
        check({16'h0, taken}, {16'h0, exp});
    endtask
    function automatic logic [4:0] vprio(input int b, input logic i2c_on);
        case (b)
            16: return 5'h15;
            17, 21: return 5'h17;
            18, 19: return 5'h16;
            20: return i2c_on ? 5'h16 : 5'h17;
            default: return (b < 8) ? 5'h12 : (b < 16) ? 5'h13 : 5'(b + 2);
        endcase
    endfunction

    task automatic t_regs();
        bus(1'b1, IE_ONE_OFF, 32'hff);
        bus(1'b0, IE_ONE_OFF, 32'h0);
        check(rd, 32'h33);
        bus(1'b1, 8'h40, 32'hff);
        check(rd, 32'h0);
        do_reset();
        bus(1'b0, IE_ONE_OFF, 32'h0);
        check(rd, 32'h0);
    endtask
    task automatic t_modes();
        logic [7:0] ctl [7] = '{8'h00, 8'h01, 8'h05, 8'h09, 8'h0d, 8'h0f, 8'h05};
        logic [4:0] exp [7] = '{5'h1f, 5'h1b, 5'h19, 5'h13, 5'h11, 5'h00, 5'h1b};
        for (int i = 0; i < 7; i++) begin
            dco_used <= (i == 6);
            bus(1'b1, MODE_CTL_OFF, {24'h0, ctl[i]});
            bus(1'b0, STATUS_OFF, 32'h0);
            check({27'h0, gate}, {27'h0, exp[i]});
            check({31'h0, halt}, {31'h0, i > 0});
            check({29'h0, rd[2:0]}, (i == 6) ? 32'h2 : i);
            if (i == 0) check({30'h0, rd[5:4]}, 32'h1);
        end
    endtask
    task automatic t_wake();
        bus(1'b1, MODE_CTL_OFF, 32'h1d);
        irq <= lpiv_irq_t'(28'h1);
        wait_sig(irq_ack);
        irq <= '0;
        repeat (2) @(posedge clk_i);
        check({26'h0, halt, gate}, 32'h1f);
        wait_sig(reti);
        repeat (3) @(posedge clk_i);
        check({26'h0, halt, gate}, 32'h31);
    endtask
    task automatic t_vectors();
        bus(1'b1, IE_ONE_OFF, 32'h01);
        bus(1'b1, MODE_CTL_OFF, 32'h10);
        wdt_int <= 1'b1;
        for (int m = 0; m < 2; m++) begin
            i2c <= m[0];
            cpu_wait <= m[0] ? 4'h3 : 4'h0;
            for (int b = 0; b < 28; b++) begin
                if (b != 17 || m == 1) begin
                    irq <= lpiv_irq_t'(28'h1 << b);
                    take(VEC_BASE + {10'h0, vprio(b, m[0]), 1'b0});
                end
            end
        end
        irq <= '1;
        take(16'hfffa);
        wdt_int <= 1'b0;
        irq <= lpiv_irq_t'(28'h1 << 24);
        repeat (8) @(posedge clk_i);
        check({31'h0, req}, 32'h0);
        irq <= '0;
    endtask
    // Non-maskable class: global enable off throughout, individual enable decides.
    task automatic t_nmi();
        bus(1'b1, MODE_CTL_OFF, 32'h00);
        bus(1'b1, IE_ONE_OFF, 32'h00);
        osc <= 1'b1;
        repeat (8) @(posedge clk_i);
        check({31'h0, req}, 32'h0);
        bus(1'b1, IE_ONE_OFF, 32'h32);
        take(VEC_NMI);
        accv <= 1'b1;
        take(VEC_NMI);
        nmi <= 1'b1;
        take(VEC_NMI);
        bus(1'b1, IE_ONE_OFF, 32'h00);
    endtask
    task automatic t_key_fetch();
        logic [15:0] kw [3] = '{KEY_DISABLE, KEY_NO_ERASE, 16'h1234};
        logic [15:0] fa [8] = '{16'h0, 16'h01ff, 16'h0400, 16'h0fff, 16'h0200, 16'h03ff,
                                16'h1000, 16'hf000};
        for (int i = 0; i < 3; i++) begin
            kword <= kw[i];
            repeat (3) @(posedge clk_i);
            check({30'h0, ldr_off, no_er}, 32'h2 >> i);
        end
        for (int i = 0; i < 8; i++) begin
            fetch <= 1'b1;
            faddr <= fa[i];
            @(posedge clk_i);
            fetch <= 1'b0;
            @(posedge clk_i);
            check({31'h0, frst}, {31'h0, i < 4});
            repeat (4) @(posedge clk_i);
        end
    endtask
    task automatic t_erased();
        rword <= ERASED_WORD;
        do_reset();
        repeat (4) @(posedge clk_i);
        check({26'h0, halt, gate}, 32'h20);
        rword <= 16'hc000;
        do_reset();
        pin_rst <= 1'b1;
        @(posedge clk_i);
        pin_rst <= 1'b0;
        bus(1'b0, STATUS_OFF, 32'h0);
        check({30'h0, rd[5:4]}, 32'h3);
    endtask

    task automatic finish_test();
        if (n_fail == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Watchdog sized well beyond the roughly eight hundred cycles the tests need.
    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        finish_test();
    end
    initial begin
        n_fail = 0;
        comparisons = 0;
        {cyc, stb, we, fetch, pin_rst, nmi, osc, accv, por_i, dco_used, i2c, wdt_int} = '0;
        {adr, cpu_wait, faddr, wdat, irq} = '0;
        rword = 16'hc000;
        kword = 16'h1234;
        rst_i = 1'b1;
        por_i = 1'b1;
        do_reset();
        por_i <= 1'b0;
        t_regs();
        t_modes();
        t_wake();
        t_vectors();
        t_nmi();
        t_key_fetch();
        t_erased();
        finish_test();
    end
endmodule // tb_lowpower_interrupt_vectoring
